// file: acmp_map.svh
// Purpose: Register offsets, field positions and reset values of the comparator control block
// Assumes: Register offsets are word indices; byte address is four times the index
// Notes:   Definitions only
`ifndef ACMP_MAP_SVH
`define ACMP_MAP_SVH

// ****************************************************************
// Register indices
// ****************************************************************
`define ACMP_IDX_CTRL      4'h0
`define ACMP_IDX_INSEL     4'h2
`define ACMP_IDX_INTEN     4'h6
`define ACMP_IDX_STATUS    4'h7
`define ACMP_IDX_INTMASK   4'h8

// ****************************************************************
// Control fields
// ****************************************************************
`define ACMP_CTRL_STDBY    7
`define ACMP_CTRL_PADEN    6
`define ACMP_CTRL_EDGE_HI  5
`define ACMP_CTRL_EDGE_LO  4
`define ACMP_CTRL_LOWPWR   3
`define ACMP_CTRL_HYS_HI   2
`define ACMP_CTRL_HYS_LO   1
`define ACMP_CTRL_EN       0

// ****************************************************************
// Input-select, status and interrupt-enable fields
// ****************************************************************
`define ACMP_INSEL_INV     7
`define ACMP_INSEL_POS_HI  4
`define ACMP_INSEL_POS_LO  3
`define ACMP_INSEL_NEG_HI  1
`define ACMP_INSEL_NEG_LO  0
`define ACMP_INSEL_MASK    8'h9B
`define ACMP_STAT_STATE    4
`define ACMP_STAT_FLAG     0
`define ACMP_INTEN_BIT     0

// ****************************************************************
// Reset values
// ****************************************************************
`define ACMP_RST_BYTE      8'h00

`endif

// file: acmp_pkg.sv
// Purpose: Types shared by the comparator control block
// Assumes: Used with acmp_map.svh
// Notes:   Edge and power encodings
package acmp_pkg;
   // Edge select codes
   typedef enum logic [1:0] {
      ACMP_ANY_EDGE  = 2'h0,
      ACMP_EDGE_RSVD = 2'h1,
      ACMP_FALL_EDGE = 2'h2,
      ACMP_RISE_EDGE = 2'h3
   } acmp_edge_t;

   // Sleep state from the power manager
   typedef enum logic [1:0] {
      ACMP_SLP_ACTIVE  = 2'h0,
      ACMP_SLP_IDLE    = 2'h1,
      ACMP_SLP_STANDBY = 2'h2,
      ACMP_SLP_PWRDOWN = 2'h3
   } acmp_sleep_t;

   // Bus slave states
   typedef enum logic [1:0] {
      ACMP_BUS_IDLE = 2'b01,
      ACMP_BUS_ACK  = 2'b10
   } acmp_bus_t;
endpackage

// file: acmp_regs.sv
// Purpose: Control and status registers around an analog voltage comparator
// Assumes: Classic Wishbone slave, 32-bit data, 10 MHz clock, synchronous reset
// Notes:   The analog core sits outside; this block drives its controls
`timescale 1ns/1ps
`default_nettype none
`include "acmp_map.svh"

module acmp_regs (
   // Clock and reset
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   // Wishbone slave
   input  wire logic                cyc_i,
   input  wire logic                stb_i,
   input  wire logic                we_i,
   input  wire logic [5:0]          adr_i,
   input  wire logic [3:0]          sel_i,
   input  wire logic [31:0]         dat_i,
   output logic      [31:0]         dat_o,
   output logic                     ack_o,
   // Power manager
   input  wire acmp_pkg::acmp_sleep_t sleep_i,
   // Analog comparator core
   input  wire logic                cmp_raw_i,
   output logic                     cmp_enable_o,
   output logic                     cmp_lowpwr_o,
   output logic      [1:0]          cmp_hyst_o,
   output logic      [1:0]          cmp_pos_sel_o,
   output logic      [1:0]          cmp_neg_sel_o,
   output logic                     cmp_invert_o,
   // Pad, event and interrupt
   output logic                     pad_out_o,
   output logic                     pad_oe_n_o,
   output logic                     event_o,
   output logic                     irq_o
);
   import acmp_pkg::*;

   // Overview of the datapath:
   // The raw comparator level enters a three-stage synchronizer. A change
   // counts only once the second and third stages agree, so a glitch that
   // lasts one clock never reaches status or the sticky flag.
   // Status state, previous level and the sticky flag all work on the
   // synchronized level, after the optional inversion.
   // Pad and event outputs take the live level instead, with one flop of
   // delay only, since the event path is meant to be fast and unsynchronized.
   // Standby and power-down freeze status and stop the flag from being set; pad and event still
   // follow the comparator in standby when run_in_standby is set.
   // The interrupt output needs the flag, the enable and the mask bit.
   // The bus answers every request one cycle after it is taken, so a master
   // sees ack in the cycle after its request and must drop stb by the end of it.

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      acmp_bus_t  bus;      // Bus slave phase
      logic [31:0] rdat;    // Read data
      logic [7:0] ctrl;     // Control register
      logic [7:0] insel;    // Input select register
      logic [7:0] inten;    // Interrupt enable register
      logic [7:0] mask;     // Status interrupt mask
      logic       flag;     // Sticky edge flag
      logic       state;    // Visible comparator state
      logic [2:0] sync;     // Three-stage synchronizer
      logic       prev;     // Previous state for edges
      logic       run;      // Comparator running
      logic       irq;      // Registered interrupt
      logic       pad;      // Pad level
      logic       pad_oe_n; // Pad enable, low drives
      logic       evt;      // Event level
   } acmp_state_t;

   acmp_state_t st_r;   // Current state
   acmp_state_t st_nxt; // Next state

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Byte-lane merge of a write into an 8-bit register
   function automatic logic [7:0] acmp_merge(input logic [7:0] old_v,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
      acmp_merge = be[0] ? wd[7:0] : old_v;
   endfunction

   logic [3:0] idx;      // Word index
   logic       wr;       // Write strobe
   logic       cmp_lvl;  // Inverted raw level
   logic       clocked;  // Register logic clocked
   logic       edge_hit; // Chosen edge seen
   logic       cur;      // Synchronized, inverted level
   acmp_edge_t edge_sel; // Edge select field

   assign idx      = adr_i[5:2];
   assign wr       = cyc_i && stb_i && we_i && (st_r.bus == ACMP_BUS_IDLE);
   assign cmp_lvl  = cmp_raw_i ^ st_r.insel[`ACMP_INSEL_INV];
   assign edge_sel = acmp_edge_t'(st_r.ctrl[`ACMP_CTRL_EDGE_HI:`ACMP_CTRL_EDGE_LO]);
   // Standby stops the peripheral clock; status freezes and the flag cannot be set then
   assign clocked  = (sleep_i != ACMP_SLP_STANDBY) && (sleep_i != ACMP_SLP_PWRDOWN);
   assign cur      = st_r.sync[2] ^ st_r.insel[`ACMP_INSEL_INV];

   // Edge decode on the synchronized level
   always_comb begin
      edge_hit = 1'b0;
      case (edge_sel)
         ACMP_ANY_EDGE:  edge_hit = cur != st_r.prev;
         ACMP_FALL_EDGE: edge_hit = st_r.prev && !cur;
         ACMP_RISE_EDGE: edge_hit = !st_r.prev && cur;
         default:        edge_hit = 1'b0; // Reserved code raises nothing
      endcase
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      st_nxt = st_r;
      // Running: enabled, not powered down, standby only if allowed
      st_nxt.run = st_r.ctrl[`ACMP_CTRL_EN]
                   && (sleep_i != ACMP_SLP_PWRDOWN)
                   && ((sleep_i != ACMP_SLP_STANDBY) || st_r.ctrl[`ACMP_CTRL_STDBY]);
      // Synchronizer; only the second and third stages are read
      st_nxt.sync = {st_r.sync[1], st_r.sync[0], cmp_raw_i};
      if (clocked) begin
         // Agreeing stages make the change count
         if (st_r.sync[2] == st_r.sync[1]) begin
            st_nxt.state = cur;
            st_nxt.prev  = cur;
            if (st_r.run && edge_hit) begin
               st_nxt.flag = 1'b1;
            end
         end
      end
      // Bus slave
      case (st_r.bus)
         ACMP_BUS_IDLE: begin
            if (cyc_i && stb_i) begin
               st_nxt.bus  = ACMP_BUS_ACK;
               st_nxt.rdat = 32'h0000_0000;
               case (idx)
                  `ACMP_IDX_CTRL: begin
                     st_nxt.rdat[7:0] = st_r.ctrl;
                     if (wr) st_nxt.ctrl = acmp_merge(st_r.ctrl, dat_i, sel_i);
                  end
                  `ACMP_IDX_INSEL: begin
                     st_nxt.rdat[7:0] = st_r.insel;
                     if (wr) st_nxt.insel = acmp_merge(st_r.insel, dat_i, sel_i)
                                            & `ACMP_INSEL_MASK;
                  end
                  `ACMP_IDX_INTEN: begin
                     st_nxt.rdat[7:0] = {7'h00, st_r.inten[`ACMP_INTEN_BIT]};
                     if (wr) st_nxt.inten = acmp_merge(st_r.inten, dat_i, sel_i)
                                            & 8'h01;
                  end
                  `ACMP_IDX_STATUS: begin
                     st_nxt.rdat[7:0] = {3'h0, st_r.state, 3'h0, st_r.flag};
                     // Set wins over clear in the same cycle
                     if (wr && sel_i[0] && dat_i[`ACMP_STAT_FLAG]
                         && !(clocked && st_r.run && edge_hit
                              && (st_r.sync[2] == st_r.sync[1]))) begin
                        st_nxt.flag = 1'b0;
                     end
                  end
                  `ACMP_IDX_INTMASK: begin
                     st_nxt.rdat[7:0] = {7'h00, st_r.mask[0]};
                     if (wr) st_nxt.mask = acmp_merge(st_r.mask, dat_i, sel_i) & 8'h01;
                  end
                  default: st_nxt.rdat = 32'h0000_0000; // Unmapped reads zero
               endcase
            end
         end
         ACMP_BUS_ACK: st_nxt.bus = ACMP_BUS_IDLE;
         default:      st_nxt.bus = ACMP_BUS_IDLE;
      endcase
      // Interrupt: enable and mask both gate the flag
      st_nxt.irq = st_nxt.flag && st_nxt.inten[0] && st_nxt.mask[0];
      // Pad and event follow the live level; power-down kills the pad
      st_nxt.pad      = st_nxt.run && cmp_lvl;
      st_nxt.pad_oe_n = !(st_nxt.run && st_nxt.ctrl[`ACMP_CTRL_PADEN]
                          && (sleep_i != ACMP_SLP_PWRDOWN));
      st_nxt.evt      = st_nxt.run && cmp_lvl;
      if (rst_i) begin
         st_nxt = '0;
         st_nxt.bus = ACMP_BUS_IDLE;
         st_nxt.pad_oe_n = 1'b1;
      end
   end

   // Register the whole state
   // Reset is folded into the next-state logic above, so this process has
   // no reset branch and every field of the state updates on every edge.
   // A trade-off: reset costs a little logic in front of every flop, but
   // one process keeps the whole block in a single registered image.
   always_ff @(posedge clk_i) begin
      st_r <= st_nxt;
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign dat_o         = st_r.rdat;
   // One-hot bus state: the upper bit is the answer phase itself
   assign ack_o         = st_r.bus[1];
   assign cmp_enable_o  = st_r.run;
   assign cmp_lowpwr_o  = st_r.ctrl[`ACMP_CTRL_LOWPWR];
   assign cmp_hyst_o    = st_r.ctrl[`ACMP_CTRL_HYS_HI:`ACMP_CTRL_HYS_LO];
   assign cmp_pos_sel_o = st_r.insel[`ACMP_INSEL_POS_HI:`ACMP_INSEL_POS_LO];
   assign cmp_neg_sel_o = st_r.insel[`ACMP_INSEL_NEG_HI:`ACMP_INSEL_NEG_LO];
   assign cmp_invert_o  = st_r.insel[`ACMP_INSEL_INV];
   assign pad_out_o     = st_r.pad;
   assign pad_oe_n_o    = st_r.pad_oe_n;
   assign event_o       = st_r.evt;
   assign irq_o         = st_r.irq;

   // ****************************************************************
   // Checks
   // ****************************************************************
   sequence flag_set_s;
      !st_r.flag ##1 st_r.flag;
   endsequence

   irq_follows_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 (irq_o == ($past(st_nxt.flag) && $past(st_nxt.inten[0]) && $past(st_nxt.mask[0]))))
      else $error("irq not tied to flag and enables");
   ack_one_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o)
      else $error("ack held too long");
   ack_after_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !ack_o) |=> ack_o)
      else $error("request not answered");
   pwrdown_pad_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (sleep_i == ACMP_SLP_PWRDOWN) |=> pad_oe_n_o && !cmp_enable_o)
      else $error("pad driven in power-down");
   flag_needs_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
      flag_set_s |-> $past(st_r.run, 1))
      else $error("flag set while halted");
   standby_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (sleep_i == ACMP_SLP_STANDBY) |=> $stable(st_r.state))
      else $error("status moved in standby");
   clear_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && idx == `ACMP_IDX_STATUS && sel_i[0] && dat_i[0] && !edge_hit) |=> !st_r.flag)
      else $error("flag not cleared");
   state_sync_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (clocked && st_r.sync[2] == st_r.sync[1]) |=> (st_r.state == $past(cur)))
      else $error("state not from synchronizer");
   rsvd_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (edge_sel == ACMP_EDGE_RSVD) |-> !edge_hit)
      else $error("reserved edge code raised flag");

   // ****************************************************************
   // Further checks on registers, pins and the interrupt path
   // ****************************************************************
   // A request taken in the idle phase
   sequence bus_req_s;
      cyc_i && stb_i && !ack_o;
   endsequence

   // The answer: one cycle of ack, then low again
   sequence bus_ans_s;
      ack_o ##1 !ack_o;
   endsequence

   // Every request is answered once, one cycle later
   req_then_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_req_s |=> bus_ans_s)
      else $error("request not answered once");

   // A control write lands as written
   ctrl_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && idx == `ACMP_IDX_CTRL && sel_i[0]) |=> (st_r.ctrl == $past(dat_i[7:0])))
      else $error("control write lost");

   // Input-select keeps only its defined bits
   insel_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && idx == `ACMP_IDX_INSEL && sel_i[0])
      |=> (st_r.insel == ($past(dat_i[7:0]) & `ACMP_INSEL_MASK)))
      else $error("input select write lost");

   // Interrupt enable holds bit zero only
   inten_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && idx == `ACMP_IDX_INTEN && sel_i[0]) |=> (st_r.inten == {7'h00, $past(dat_i[0])}))
      else $error("interrupt enable write lost");

   // Without the low lane nothing is written
   lane_guard_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && !sel_i[0]) |=> ($stable(st_r.ctrl) && $stable(st_r.insel)))
      else $error("write without lane enable");

   // Upper read lanes are always zero
   read_upper_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |-> (dat_o[31:8] == 24'h000000))
      else $error("upper read lanes not zero");

   // Unmapped places read zero
   unmapped_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (bus_req_s and (!(idx inside {`ACMP_IDX_CTRL, `ACMP_IDX_INSEL, `ACMP_IDX_INTEN,
                                   `ACMP_IDX_STATUS, `ACMP_IDX_INTMASK})))
      |=> (dat_o == 32'h0000_0000))
      else $error("unmapped read not zero");

   // A driven pad needs the pad enable and a running comparator
   pad_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !pad_oe_n_o |-> (st_r.ctrl[`ACMP_CTRL_PADEN] && cmp_enable_o))
      else $error("pad driven without enable");

   // Event follows the live, optionally inverted level
   event_live_a: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |=> (event_o == ($past(st_nxt.run) && $past(cmp_lvl))))
      else $error("event not from live level");

   // A cleared enable bit stops comparator, pad and event
   disabled_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !st_r.ctrl[`ACMP_CTRL_EN] |=> (!cmp_enable_o && !event_o && !pad_out_o))
      else $error("comparator active while disabled");

   // Standby halts the comparator unless run_in_standby is set
   standby_halt_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ((sleep_i == ACMP_SLP_STANDBY) && !st_r.ctrl[`ACMP_CTRL_STDBY]) |=> !cmp_enable_o)
      else $error("comparator ran in standby");

   // No flag is raised while the clock is stopped
   standby_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ((sleep_i == ACMP_SLP_STANDBY) && !st_r.flag) |=> !st_r.flag)
      else $error("flag set in standby");

   // A chosen edge that counts while running and clocked sets the flag, even against a clear
   edge_sets_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (clocked && st_r.run && edge_hit && (st_r.sync[2] == st_r.sync[1])) |=> st_r.flag)
      else $error("edge did not set flag");

   // Falling-only mode ignores a rising edge
   fall_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ((edge_sel == ACMP_FALL_EDGE) && !st_r.prev && cur) |-> !edge_hit)
      else $error("rising edge seen in falling mode");

   // Writing zero to status leaves the flag alone
   write_zero_keeps_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && idx == `ACMP_IDX_STATUS && !dat_i[`ACMP_STAT_FLAG] && st_r.flag) |=> st_r.flag)
      else $error("flag lost on zero write");

   // Interrupt level matches flag, enable and mask
   irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_o == (st_r.flag && st_r.inten[0] && st_r.mask[0]))
      else $error("irq level wrong");
endmodule

`default_nettype wire

// file: testbench.sv
// Purpose: Self-checking bench for the comparator control registers
// Assumes: Classic Wishbone single cycles, 10 MHz clock, bench drives the raw output
// Notes:   Register images and the flag are modelled here and compared at each result
`timescale 1ns/1ps
`default_nettype none
`include "acmp_map.svh"

module testbench;
   import acmp_pkg::*;
   // ********
   // Signals
   // ********
   logic        clk_i = 1'b0;        // Bus clock
   logic        rst_i = 1'b1;        // Held for 20 cycles
   logic        cyc_i = 1'b0;        // Bus cycle
   logic        stb_i = 1'b0;        // Bus strobe
   logic        we_i = 1'b0;         // Write select
   logic [5:0]  adr_i = 6'h00;       // Byte address
   logic [3:0]  sel_i = 4'hF;        // Lane enables
   logic [31:0] dat_i = 32'h0;       // Write data
   logic [31:0] dat_o;               // Read data
   logic        ack_o;               // Bus answer
   acmp_sleep_t sleep_i = ACMP_SLP_ACTIVE; // Power state
   logic        cmp_raw_i = 1'b0;    // Analog core output
   logic        cmp_enable_o, cmp_lowpwr_o, cmp_invert_o;
   logic [1:0]  cmp_hyst_o, cmp_pos_sel_o, cmp_neg_sel_o;
   logic        pad_out_o, pad_oe_n_o, event_o, irq_o;
   logic [7:0]  m_ctrl = 8'h00, m_insel = 8'h00; // Model images
   logic        m_flag = 1'b0, m_state = 1'b0;   // Model status
   int          err_count = 0, comparisons = 0, seed = 73991;
   logic [31:0] v;                   // Random draw

   always #50 clk_i = ~clk_i;        // 100 ns period

   acmp_regs acmp_regs_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .sleep_i(sleep_i), .cmp_raw_i(cmp_raw_i),
      .cmp_enable_o(cmp_enable_o), .cmp_lowpwr_o(cmp_lowpwr_o), .cmp_hyst_o(cmp_hyst_o),
      .cmp_pos_sel_o(cmp_pos_sel_o), .cmp_neg_sel_o(cmp_neg_sel_o),
      .cmp_invert_o(cmp_invert_o), .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o),
      .event_o(event_o), .irq_o(irq_o));

   // ********
   // Tasks
   // ********
   // Verdict and end of run, also used by the watchdog
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Case equality so an unknown never matches
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t ns: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // One classic cycle; request held until ack is seen at an edge
   task automatic wb(input logic w, input logic [3:0] idx, input logic [7:0] d,
                     output logic [7:0] q);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= {idx, 2'b00};
      dat_i <= {24'h0, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      q = dat_o[7:0];
      if (n >= 20) chk(16'h0, 16'h1, "no ack");
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask

   // Write and keep the model in step
   task automatic wr(input logic [3:0] idx, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, idx, d, q);
      if (idx == `ACMP_IDX_CTRL) m_ctrl = d;
      if (idx == `ACMP_IDX_INSEL) m_insel = d & `ACMP_INSEL_MASK;
      if (idx == `ACMP_IDX_STATUS && d[0]) m_flag = 1'b0;
   endtask

   task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      wb(1'b0, idx, 8'h00, q);
      chk({8'h0, q}, {8'h0, exp}, "read");
   endtask

   // Status image: state in bit 4, flag in bit 0
   task automatic stat();
      rd(`ACMP_IDX_STATUS, {3'h0, m_state, 3'h0, m_flag});
   endtask

   // Analog controls, pad and event against the model; outputs settle first
   task automatic outs();
      logic en;
      logic o;
      repeat (3) @(posedge clk_i);
      en = m_ctrl[0] && sleep_i != ACMP_SLP_PWRDOWN
           && (sleep_i != ACMP_SLP_STANDBY || m_ctrl[7]);
      o = en && (cmp_raw_i ^ m_insel[7]);
      chk({4'h0, cmp_enable_o, cmp_lowpwr_o, cmp_hyst_o, cmp_pos_sel_o, cmp_neg_sel_o,
           cmp_invert_o, pad_oe_n_o, pad_out_o, event_o},
          {4'h0, en, m_ctrl[3:1], m_insel[4:3], m_insel[1:0], m_insel[7],
           !(en && m_ctrl[6]), o, o}, "pins");
   endtask

   // ********
   // Watchdog: whole sequence needs well under 5000 cycles
   // ********
   initial begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      conclude();
   end

   // ********
   // Main sequence
   // ********
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      // Every mapped place and one unmapped place read zero after reset
      rd(`ACMP_IDX_CTRL, 8'h00);
      rd(`ACMP_IDX_INSEL, 8'h00);
      rd(`ACMP_IDX_INTEN, 8'h00);
      rd(`ACMP_IDX_STATUS, 8'h00);
      rd(`ACMP_IDX_INTMASK, 8'h00);
      outs();
      wr(4'h3, 8'hFF);
      rd(4'h3, 8'h00);
      // Random control and input-select values reach the analog controls
      for (int i = 0; i < 8; i++) begin
         v = $random(seed);
         wr(`ACMP_IDX_CTRL, v[7:0]);
         wr(`ACMP_IDX_INSEL, v[15:8]);
         rd(`ACMP_IDX_CTRL, m_ctrl);
         rd(`ACMP_IDX_INSEL, m_insel);
         outs();
      end
      // Every edge code, rising then falling, with and without the enable
      for (int e = 0; e < 4; e++) begin
         wr(`ACMP_IDX_CTRL, 8'h01 | 8'(e << 4));
         wr(`ACMP_IDX_INSEL, 8'h00);
         wr(`ACMP_IDX_INTMASK, 8'h01);
         wr(`ACMP_IDX_INTEN, 8'h01);
         repeat (8) @(posedge clk_i);
         wr(`ACMP_IDX_STATUS, 8'h01);
         m_state = 1'b0;
         stat();
         cmp_raw_i <= 1'b1;
         m_state = 1'b1;
         m_flag = (e == 0 || e == 3);
         repeat (8) @(posedge clk_i);
         stat();
         chk({15'h0, irq_o}, {15'h0, m_flag}, "irq");
         wr(`ACMP_IDX_STATUS, 8'h00);
         stat();
         wr(`ACMP_IDX_STATUS, 8'h01);
         wr(`ACMP_IDX_INTEN, 8'(e & 1));
         cmp_raw_i <= 1'b0;
         m_state = 1'b0;
         m_flag = (e == 0 || e == 2);
         repeat (8) @(posedge clk_i);
         stat();
         chk({15'h0, irq_o}, {15'h0, m_flag && e[0]}, "irq");
      end
      // Inverted output on pad, event and state
      wr(`ACMP_IDX_CTRL, 8'h41);
      wr(`ACMP_IDX_INSEL, 8'h80);
      outs();
      repeat (6) @(posedge clk_i);
      wr(`ACMP_IDX_STATUS, 8'h01);
      m_state = 1'b1;
      stat();
      // Each sleep state with and without run in standby
      for (int k = 0; k < 8; k++) begin
         sleep_i <= acmp_sleep_t'(k >> 1);
         wr(`ACMP_IDX_CTRL, k[0] ? 8'hC1 : 8'h41);
         outs();
      end
      // Standby holds status even while running; the change lands on wake
      sleep_i <= ACMP_SLP_ACTIVE;
      wr(`ACMP_IDX_STATUS, 8'h01);
      sleep_i <= ACMP_SLP_STANDBY;
      cmp_raw_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      stat();
      sleep_i <= ACMP_SLP_ACTIVE;
      repeat (8) @(posedge clk_i);
      m_state = 1'b0;
      m_flag = 1'b1;
      stat();
      chk({15'h0, irq_o}, 16'h0001, "irq");
      wr(`ACMP_IDX_INTMASK, 8'h00);
      chk({15'h0, irq_o}, 16'h0000, "irq masked");
      conclude();
   end
endmodule
`default_nettype wire
